// >>> swq_cpu_model.sv
// Purpose: Behavioural management processor that issues APB register cycles
// Assumes: The slave answers with PREADY within a bounded wait
// Notes: A request is held until the edge that samples PREADY high
`timescale 1ns/1ps
`default_nettype none
module swq_cpu_model (
	input wire logic clk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// =========================================
	// One APB cycle; a dead slave is caught by the bench watchdog
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> swq_pkg.sv
// Purpose: Shared constants for the switch port QoS and spanning-tree gating block
// Assumes: APB register map with one 32-bit word per register
// Notes: Per-port register groups repeat at a fixed stride
package swq_pkg;
	localparam int NPORT = 5;
	localparam logic [11:0] OFS_GLOBAL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_DSCP0 = 12'h010;
	localparam logic [11:0] OFS_PORT0 = 12'h040;
	localparam logic [11:0] PORT_STRIDE = 12'h010;
	localparam logic [11:0] OFS_PCFG = 12'h000;
	localparam logic [11:0] OFS_PSTP = 12'h004;
	localparam logic [11:0] OFS_PWGT = 12'h008;
	// Global word fields
	localparam int GL_TWOQ_LO = 6;
	localparam int GL_PMAP_LO = 16;
	localparam logic [31:0] GLOBAL_RST = 32'hE4000000;
	// Port config word fields
	localparam int PC_SPLIT_LO = 0;
	localparam int PC_REMOVE = 1;
	localparam int PC_INSERT = 2;
	localparam int PC_PPRIO_LO = 3;
	localparam int PC_DOT1P_EN = 5;
	localparam int PC_DSCP_EN = 6;
	localparam int PC_CEILING = 7;
	localparam int PC_SPLIT_HI = 9;
	localparam int PC_STRICT = 10;
	localparam int PC_INSMASK_LO = 11;
	localparam int PC_TAG_LO = 16;
	localparam logic [31:0] PCFG_RST = 32'h00000000;
	// Spanning-tree word fields
	localparam int ST_TX_EN = 0;
	localparam int ST_RX_EN = 1;
	localparam int ST_LEARN_DIS = 2;
	localparam logic [31:0] PSTP_RST = 32'h00000003;
	// Queue weights, one per byte lane, queue 0 in the low byte
	localparam logic [31:0] PWGT_RST = 32'h01020408;
	localparam logic [1:0] QMODE_ONE = 2'h0;
	localparam logic [1:0] QMODE_TWO = 2'h1;
	localparam logic [1:0] QMODE_FOUR = 2'h2;
endpackage

// >>> swq_qos_stp.sv
// Purpose: Frame classification, egress tag handling, queue service and STP gating
// Assumes: One descriptor per cycle at most; APB slave with one wait state
// Notes: Port index 0..3 are ports 1-4, index 4 is the processor port
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01: Per-port two-bit mode selects one, two or four egress queues.
// RULE_02: In four-queue mode queue 3 is highest, queue 0 lowest.
// RULE_03: Without a split every frame lands in the same single queue.
// RULE_04: Queues served strictly or by weighted fair queuing, 7-bit weights 8,4,2,1.
// RULE_05: Global two-bit map sends a 2-bit level to high or low queue.
// RULE_06: Port-based priority gives every ingress frame the port's level 0..3.
// RULE_07: Priority-3 port frames go to the high queue when split.
// RULE_08: Tagged frame 3-bit priority maps through a table to level 0..3.
// RULE_09: 802.1p classification only with per-port enable; untagged frames get none.
// RULE_10: Insert ingress port default tag into untagged frames, per source mask.
// RULE_11: Never insert a second tag into an already tagged frame.
// RULE_12: Tag removal strips the four-byte tag from tagged frames.
// RULE_13: Untagged frames pass unchanged through a removing port.
// RULE_14: Frame check sequence is recomputed whenever a tag is added or removed.
// RULE_15: Priority ceiling lowers frame priority to the port default tag priority.
// RULE_16: Upper six ToS bits index a 128-bit table of 2-bit levels.
// RULE_17: Disable state: no user forwarding, no receiving, no learning. Code: frames with FRM_TO_CPU are still received in every state.
// RULE_18: Blocking state forwards only frames to the processor, no learning.
// RULE_19: Listening state forwards only processor traffic, learning off.
// RULE_20: Learning state forwards only processor traffic but learns addresses.
// RULE_21: Forwarding state forwards and receives normally and learns.
// RULE_22: Processor avoids blocked ports and installs overriding static entries.
// RULE_23: Several enabled methods resolve to the highest level any yields.
module swq_qos_stp
	import swq_pkg::*;
#(
	parameter int WGT_W = 7
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic FRM_VALID,
	input wire logic [2:0] FRM_SRC,
	input wire logic [2:0] FRM_DST,
	input wire logic FRM_TAGGED,
	input wire logic [2:0] FRM_PCP,
	input wire logic FRM_IPV4,
	input wire logic [7:0] FRM_TOS,
	input wire logic FRM_TO_CPU,
	input wire logic FRM_FROM_CPU,
	output logic CLS_VALID,
	output logic [1:0] CLS_QUEUE,
	output logic CLS_FWD,
	output logic CLS_LEARN,
	output logic CLS_INSERT,
	output logic CLS_REMOVE,
	output logic CLS_FCS_REDO,
	output logic [2:0] CLS_PCP,
	output logic [15:0] CLS_TAG,
	input wire logic SCH_REQ,
	input wire logic [2:0] SCH_PORT,
	input wire logic [3:0] SCH_PEND,
	output logic SCH_GNT,
	output logic [1:0] SCH_QUEUE
);

	// ==========================================================
	// Decoding helpers
	function automatic logic [1:0] qmode(input logic [31:0] cfg);
		qmode = {cfg[PC_SPLIT_HI], cfg[PC_SPLIT_LO]};
	endfunction

	function automatic logic [1:0] pmap(input logic [31:0] glb, input logic [2:0] pcp);
		pmap = glb[GL_PMAP_LO + 2 * pcp +: 2];
	endfunction

	function automatic logic [1:0] max2(input logic [1:0] a, input logic [1:0] b);
		max2 = (a > b) ? a : b;
	endfunction

	// ==========================================================
	// Register storage
	logic [31:0] glb, next_glb;
	logic [127:0] dscp, next_dscp;
	logic [31:0] pcfg [NPORT];
	logic [31:0] next_pcfg [NPORT];
	logic [31:0] pstp [NPORT];
	logic [31:0] next_pstp [NPORT];
	logic [31:0] pwgt [NPORT];
	logic [31:0] next_pwgt [NPORT];
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [3:0] status, next_status;

	// ==========================================================
	// APB slave
	logic acc, wr_now;
	logic [11:0] rel;
	logic [2:0] pidx;
	logic [11:0] psub;
	logic hit_port, hit_dscp;

	always_comb begin
		acc = PSEL && PENABLE;
		wr_now = acc && PWRITE && PREADY;
		rel = PADDR - OFS_PORT0;
		pidx = 3'(rel / PORT_STRIDE);
		psub = rel % PORT_STRIDE;
		// Range test on the full offset, so addresses past the last port cannot alias one
		hit_port = (PADDR >= OFS_PORT0) && (int'(rel) < NPORT * int'(PORT_STRIDE)) &&
			(psub <= OFS_PWGT) && (PADDR[1:0] == 2'h0);
		hit_dscp = (PADDR[11:4] == OFS_DSCP0[11:4]) && (PADDR[1:0] == 2'h0);
		next_glb = glb;
		next_dscp = dscp;
		next_pcfg = pcfg;
		next_pstp = pstp;
		next_pwgt = pwgt;
		next_prdata = 32'h00000000;
		next_pslverr = 1'b0;
		next_pready = acc && !PREADY;
		if (PADDR == OFS_GLOBAL) begin
			next_prdata = glb;
			if (wr_now)
				next_glb = PWDATA;
		end else if (PADDR == OFS_STATUS) begin
			next_prdata = {28'h0000000, status};
		end else if (hit_dscp) begin
			next_prdata = dscp[32 * PADDR[3:2] +: 32];
			if (wr_now)
				next_dscp[32 * PADDR[3:2] +: 32] = PWDATA;
		end else if (hit_port) begin
			unique case (psub)
				OFS_PCFG: begin
					next_prdata = pcfg[pidx];
					if (wr_now)
						next_pcfg[pidx] = PWDATA;
				end
				OFS_PSTP: begin
					next_prdata = {29'h0, pstp[pidx][2:0]};
					if (wr_now)
						next_pstp[pidx] = {29'h0, PWDATA[2:0]};
				end
				default: begin
					next_prdata = pwgt[pidx] & 32'h7F7F7F7F;
					if (wr_now)
						next_pwgt[pidx] = PWDATA & 32'h7F7F7F7F;
				end
			endcase
		end else begin
			next_pslverr = acc;
		end
		if (!next_pready) begin
			next_prdata = 32'h00000000;
			next_pslverr = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			glb <= GLOBAL_RST;
			dscp <= '0;
			PRDATA <= 32'h00000000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			glb <= next_glb;
			dscp <= next_dscp;
			PRDATA <= next_prdata;
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
		end
	end

	for (genvar p = 0; p < NPORT; p++) begin : g_preg
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				pcfg[p] <= PCFG_RST;
				pstp[p] <= PSTP_RST;
				pwgt[p] <= PWGT_RST;
			end else begin
				pcfg[p] <= next_pcfg[p];
				pstp[p] <= next_pstp[p];
				pwgt[p] <= next_pwgt[p];
			end
		end
	end

	// ==========================================================
	// Frame classification
	logic [31:0] icfg, ecfg, istp, estp;
	logic [2:0] dflt_pcp, eff_pcp;
	logic [1:0] lvl_port, lvl_1p, lvl_ds, lvl, q;
	logic rx_ok, tx_ok, ins, rem;
	logic n_valid, n_fwd, n_learn;
	logic [1:0] n_queue;
	logic [2:0] n_pcp;
	logic [15:0] n_tag;
	logic src_ok, dst_ok;

	always_comb begin
		src_ok = int'(FRM_SRC) < NPORT;
		dst_ok = int'(FRM_DST) < NPORT;
		icfg = src_ok ? pcfg[FRM_SRC] : 32'h00000000;
		ecfg = dst_ok ? pcfg[FRM_DST] : 32'h00000000;
		istp = src_ok ? pstp[FRM_SRC] : 32'h00000000;
		estp = dst_ok ? pstp[FRM_DST] : 32'h00000000;
		dflt_pcp = icfg[PC_TAG_LO + 13 +: 3];
		eff_pcp = FRM_PCP;
		if (icfg[PC_CEILING] && FRM_TAGGED && (FRM_PCP > dflt_pcp))
			eff_pcp = dflt_pcp; // RULE_15
		lvl_port = icfg[PC_PPRIO_LO +: 2]; // RULE_06
		lvl_1p = (icfg[PC_DOT1P_EN] && FRM_TAGGED) ? pmap(glb, eff_pcp) : 2'h0; // RULE_08 RULE_09
		lvl_ds = (icfg[PC_DSCP_EN] && FRM_IPV4) ? dscp[2 * FRM_TOS[7:2] +: 2] : 2'h0; // RULE_16
		lvl = max2(lvl_port, max2(lvl_1p, lvl_ds)); // RULE_23
		unique case (qmode(ecfg)) // RULE_01
			QMODE_TWO: q = {1'b0, lvl >= glb[GL_TWOQ_LO +: 2]}; // RULE_05 RULE_07
			QMODE_FOUR: q = lvl; // RULE_02
			default: q = 2'h0; // RULE_03
		endcase
		// Port 5 has no spanning-tree gating; it is always forwarding
		rx_ok = (FRM_SRC == 3'h4) || istp[ST_RX_EN] || FRM_TO_CPU; // RULE_17 RULE_18
		tx_ok = (FRM_DST == 3'h4) || estp[ST_TX_EN] || FRM_FROM_CPU; // RULE_19 RULE_20 RULE_21
		ins = ecfg[PC_INSERT] && !FRM_TAGGED && ecfg[PC_INSMASK_LO + FRM_SRC]; // RULE_10 RULE_11
		rem = ecfg[PC_REMOVE] && FRM_TAGGED; // RULE_12 RULE_13
		n_valid = FRM_VALID && src_ok && dst_ok;
		n_fwd = n_valid && rx_ok && tx_ok;
		n_learn = n_valid && rx_ok && ((FRM_SRC == 3'h4) || !istp[ST_LEARN_DIS]); // RULE_20 RULE_21
		n_queue = n_valid ? q : 2'h0;
		n_pcp = n_valid ? eff_pcp : 3'h0;
		n_tag = (n_valid && ins) ? icfg[PC_TAG_LO +: 16] : 16'h0000;
		next_status = n_valid ? {lvl, q} : status;
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CLS_VALID <= 1'b0;
			CLS_QUEUE <= 2'h0;
			CLS_FWD <= 1'b0;
			CLS_LEARN <= 1'b0;
			CLS_INSERT <= 1'b0;
			CLS_REMOVE <= 1'b0;
			CLS_FCS_REDO <= 1'b0;
			CLS_PCP <= 3'h0;
			CLS_TAG <= 16'h0000;
			status <= 4'h0;
		end else begin
			CLS_VALID <= n_valid;
			CLS_QUEUE <= n_queue;
			CLS_FWD <= n_fwd;
			CLS_LEARN <= n_learn;
			CLS_INSERT <= n_valid && ins;
			CLS_REMOVE <= n_valid && rem;
			CLS_FCS_REDO <= n_valid && (ins || rem); // RULE_14
			CLS_PCP <= n_pcp;
			CLS_TAG <= n_tag;
			status <= next_status;
		end
	end

	// ==========================================================
	// Egress queue service; credits persist per port and queue
	logic [WGT_W-1:0] credit [NPORT][4];
	logic [WGT_W-1:0] next_credit [NPORT][4];
	logic [31:0] scfg, swgt;
	logic n_gnt, found, wfq;
	logic [1:0] n_sq;

	always_comb begin
		scfg = (int'(SCH_PORT) < NPORT) ? pcfg[SCH_PORT] : 32'h00000000;
		swgt = (int'(SCH_PORT) < NPORT) ? pwgt[SCH_PORT] : 32'h00000000;
		next_credit = credit;
		wfq = (qmode(scfg) == QMODE_FOUR) && !scfg[PC_STRICT]; // RULE_04
		found = 1'b0;
		n_sq = 2'h0;
		n_gnt = SCH_REQ && (int'(SCH_PORT) < NPORT) && (SCH_PEND != 4'h0);
		for (int i = 3; i >= 0; i--) begin
			if (!found && SCH_PEND[i] && (!wfq || credit[SCH_PORT][i] != '0)) begin
				found = 1'b1;
				n_sq = 2'(i); // RULE_02
			end
		end
		if (n_gnt && wfq) begin
			if (!found) begin
				// All pending queues spent: start a new round from the weights
				for (int i = 0; i < 4; i++)
					next_credit[SCH_PORT][i] = swgt[8 * i +: WGT_W];
				for (int i = 3; i >= 0; i--) begin
					if (!found && SCH_PEND[i]) begin
						found = 1'b1;
						n_sq = 2'(i);
					end
				end
			end
			if (next_credit[SCH_PORT][n_sq] != '0)
				next_credit[SCH_PORT][n_sq] = next_credit[SCH_PORT][n_sq] - 1'b1; // RULE_04
		end
		if (!n_gnt)
			n_sq = 2'h0;
	end

	for (genvar p = 0; p < NPORT; p++) begin : g_cred
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				for (int i = 0; i < 4; i++)
					credit[p][i] <= PWGT_RST[8 * i +: WGT_W];
			end else begin
				credit[p] <= next_credit[p];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SCH_GNT <= 1'b0;
			SCH_QUEUE <= 2'h0;
		end else begin
			SCH_GNT <= n_gnt;
			SCH_QUEUE <= n_sq;
		end
	end

	// ==========================================================
	// Checks
	sequence s_untagged_in;
		FRM_VALID && src_ok && dst_ok && !FRM_TAGGED;
	endsequence

	sequence s_cpu_to_port;
		FRM_VALID && dst_ok && FRM_SRC == 3'h4 && FRM_FROM_CPU;
	endsequence

	AST_CPU_TRAFFIC: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_19
		s_cpu_to_port |=> CLS_FWD)
		else $error("processor frame not forwarded");
	AST_FWD_STATE: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_21
		(FRM_VALID && src_ok && dst_ok && istp[ST_RX_EN] && estp[ST_TX_EN] &&
		!istp[ST_LEARN_DIS]) |=> CLS_FWD && CLS_LEARN)
		else $error("forwarding-state frame not forwarded and learned");
	AST_LEARN_STATE: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_20
		(FRM_VALID && FRM_SRC < 3'h4 && FRM_DST == 3'h4 && FRM_TO_CPU &&
		!istp[ST_LEARN_DIS]) |=> CLS_FWD && CLS_LEARN)
		else $error("processor frame not forwarded or not learned");

	AST_SINGLE_Q: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_03
		(FRM_VALID && dst_ok && qmode(ecfg) == QMODE_ONE) |=> CLS_QUEUE == 2'h0)
		else $error("single-queue port used a nonzero queue");
	AST_NO_DOUBLE_TAG: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_11
		CLS_INSERT |-> !$past(FRM_TAGGED))
		else $error("tag inserted into a tagged frame");
	AST_UNTAG_KEPT: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_13
		s_untagged_in |=> !CLS_REMOVE)
		else $error("removal applied to an untagged frame");
	AST_FCS: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_14
		CLS_FCS_REDO == (CLS_INSERT || CLS_REMOVE))
		else $error("check sequence not recomputed with tag change");
	AST_CEILING: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_15
		(FRM_VALID && src_ok && dst_ok && icfg[PC_CEILING] && FRM_TAGGED)
		|=> CLS_PCP <= $past(dflt_pcp))
		else $error("priority ceiling exceeded");
	AST_PRIO3_HIGH: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_07
		(FRM_VALID && src_ok && dst_ok && lvl_port == 2'h3 && qmode(ecfg) == QMODE_TWO)
		|=> CLS_QUEUE == 2'h1)
		else $error("priority-3 frame missed high queue");
	AST_NO_LEARN: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_17
		(FRM_VALID && FRM_SRC < 3'h4 && istp[ST_LEARN_DIS]) |=> !CLS_LEARN)
		else $error("learning while disabled");
	AST_BLOCK_FWD: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_18
		(FRM_VALID && FRM_SRC < 3'h4 && !istp[ST_RX_EN] && !FRM_TO_CPU) |=> !CLS_FWD)
		else $error("user frame forwarded from blocked port");
	AST_STRICT_TOP: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_04
		(SCH_REQ && SCH_PEND[3] && int'(SCH_PORT) < NPORT && !wfq) |=> SCH_GNT && SCH_QUEUE == 2'h3)
		else $error("strict service skipped top queue");
	AST_APB_WAIT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
		else $error("APB answer not one cycle after access");

endmodule

`default_nettype wire

// >>> swq_qos_stp_bench.sv
// Purpose: Self-checking bench for classification, tagging, STP gating and queue service
// Assumes: Reset values and field positions of the package
// Notes: Random levels come from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module swq_qos_stp_bench;
	import swq_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic fv, ftag, fip, fto, ffrom, cv, cfwd, clearn, cins, crem, cfcs, sreq, sgnt, er;
	logic [2:0] fsrc, fdst, fpcp, cpcp, sport;
	logic [7:0] ftos;
	logic [1:0] cq, sq;
	logic [15:0] ctag;
	logic [3:0] spend, pd;
	int n_fail, cmp_count, lvl, m;
	swq_qos_stp swq_qos_stp_inst (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FRM_VALID(fv),
		.FRM_SRC(fsrc), .FRM_DST(fdst), .FRM_TAGGED(ftag), .FRM_PCP(fpcp),
		.FRM_IPV4(fip), .FRM_TOS(ftos), .FRM_TO_CPU(fto), .FRM_FROM_CPU(ffrom),
		.CLS_VALID(cv), .CLS_QUEUE(cq), .CLS_FWD(cfwd), .CLS_LEARN(clearn),
		.CLS_INSERT(cins), .CLS_REMOVE(crem), .CLS_FCS_REDO(cfcs), .CLS_PCP(cpcp),
		.CLS_TAG(ctag), .SCH_REQ(sreq), .SCH_PORT(sport), .SCH_PEND(spend),
		.SCH_GNT(sgnt), .SCH_QUEUE(sq));
	swq_cpu_model swq_cpu_model_inst (.clk(clk), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	// =========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [11:0] pa(input int p, input logic [11:0] o);
		return OFS_PORT0 + PORT_STRIDE * p[11:0] + o;
	endfunction
	// Two-queue map is programmed to 3: only level 3 reaches the high queue
	function automatic logic [1:0] exp_q(input int md, input int l);
		return (md == 0) ? 2'h0 : (md == 1) ? ((l >= 3) ? 2'h1 : 2'h0) : l[1:0];
	endfunction
	// Strict service: grant the highest pending queue, none when nothing waits
	function automatic logic [2:0] exp_s(input logic [3:0] pend);
		for (int i = 3; i >= 0; i--)
			if (pend[i])
				return {1'b1, 2'(i)};
		return 3'h0;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		swq_cpu_model_inst.xfer(1'b1, a, d, rd, er);
	endtask
	task automatic frm(input int s, input int d, input logic t, input logic [2:0] p,
		input logic ip, input logic to, input logic from);
		@(posedge clk);
		fv <= 1'b1;
		fsrc <= s[2:0];
		fdst <= d[2:0];
		ftag <= t;
		fpcp <= p;
		fip <= ip;
		fto <= to;
		ffrom <= from;
		@(posedge clk);
		fv <= 1'b0;
		@(posedge clk);
		`CHK(cv, 1'b1)
	endtask
	task automatic sch(input int p, input logic [3:0] pend);
		@(posedge clk);
		sreq <= 1'b1;
		sport <= p[2:0];
		spend <= pend;
		@(posedge clk);
		sreq <= 1'b0;
		@(posedge clk);
	endtask
	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_sim();
	end
	// =========================================
	// Main sequence
	initial begin
		{rst_n, fv, ftag, fip, fto, ffrom, sreq} = 7'h00;
		{fsrc, fdst, fpcp, sport, spend} = 16'h0000;
		ftos = 8'hFC;
		n_fail = 0;
		cmp_count = 0;
		seed = 32'hE13E0D1E;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		swq_cpu_model_inst.xfer(1'b0, OFS_GLOBAL, 32'h0, rd, er);
		`CHK(rd, GLOBAL_RST)
		swq_cpu_model_inst.xfer(1'b0, pa(1, OFS_PWGT), 32'h0, rd, er);
		`CHK(rd, PWGT_RST)
		swq_cpu_model_inst.xfer(1'b0, 12'hFFC, 32'h0, rd, er);
		`CHK(er, 1'b1)
		swq_cpu_model_inst.xfer(1'b0, 12'h0F8, 32'h0, rd, er);
		`CHK(er, 1'b1)
		$display("Test registers done");
		wr(OFS_GLOBAL, GLOBAL_RST | 32'h000000C0);
		for (int i = 0; i < 12; i++) begin
			m = i % 3;
			lvl = rnd() % 4;
			wr(pa(1, OFS_PCFG), (m == 1) ? 32'h1 : (m == 2) ? 32'h200 : 32'h0);
			wr(pa(0, OFS_PCFG), lvl << PC_PPRIO_LO);
			frm(0, 1, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
			`CHK(cq, exp_q(m, lvl))
		end
		wr(pa(1, OFS_PCFG), 32'h200);
		wr(OFS_DSCP0 + 12'h00C, 32'h80000000);
		wr(pa(0, OFS_PCFG), 32'h00000068);
		frm(0, 1, 1'b0, 3'h7, 1'b1, 1'b0, 1'b0);
		`CHK(cq, 2'h2)
		frm(0, 1, 1'b1, 3'h7, 1'b1, 1'b0, 1'b0);
		`CHK(cq, GLOBAL_RST[31:30])
		swq_cpu_model_inst.xfer(1'b0, OFS_STATUS, 32'h0, rd, er);
		`CHK(rd, {28'h0, GLOBAL_RST[31:30], GLOBAL_RST[31:30]})
		$display("Test classification done");
		wr(pa(3, OFS_PCFG), 32'h00000804);
		wr(pa(0, OFS_PCFG), 32'h20050080);
		frm(0, 3, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
		`CHK({cins, cfcs, ctag}, {2'h3, 16'h2005})
		frm(1, 3, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
		`CHK(cins, 1'b0)
		frm(0, 3, 1'b1, 3'h7, 1'b0, 1'b0, 1'b0);
		`CHK({cins, cpcp}, 4'h1)
		wr(pa(3, OFS_PCFG), 32'h00000002);
		frm(0, 3, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
		`CHK({crem, cfcs, cpcp}, 5'h18)
		frm(0, 3, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
		`CHK({crem, cfcs}, 2'h0)
		$display("Test tagging done");
		for (int s = 0; s < 3; s++) begin
			m = (s == 0) ? 4 : (s == 1) ? 0 : 3;
			wr(pa(0, OFS_PSTP), m);
			frm(0, 2, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
			`CHK({cfwd, clearn}, (m == 3) ? 2'h3 : 2'h0)
			frm(2, 0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
			`CHK(cfwd, (m == 3))
			frm(0, 4, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0);
			`CHK({cfwd, clearn}, {1'b1, m != 4})
			if (m != 4) begin
				frm(4, 0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
				`CHK(cfwd, 1'b1)
			end
		end
		swq_cpu_model_inst.xfer(1'b0, pa(0, OFS_PSTP), 32'h0, rd, er);
		`CHK(rd, 32'h00000003)
		$display("Test spanning tree done");
		wr(pa(1, OFS_PCFG), 32'h600);
		for (int i = 0; i < 8; i++) begin
			pd = (i == 0) ? 4'h0 : 4'(rnd());
			sch(1, pd);
			`CHK({sgnt, sq}, exp_s(pd))
		end
		wr(pa(2, OFS_PCFG), 32'h200);
		for (int i = 0; i < 12; i++) begin
			sch(2, 4'h3);
			`CHK(sq, (i < 4) ? 2'h1 : 2'h0)
		end
		$display("Test scheduler done");
		end_sim();
	end
endmodule
`default_nettype wire
